// ---- logic/dpo_phase_link.sv ----
/*
   phase offset combiner, combo steering, satellite alignment and
   pulse-per-second shift for all loop channels.
   assumes loop filters, output converters and servo share sys_clk.
*/
`timescale 1ns/1ps
module dpo_phase_link
#(
   parameter int NUM_CH = dpo_pkg::NUM_CH,
   parameter int NUM_IN = dpo_pkg::NUM_IN
)
(
   input  wire logic                                         sys_clk,
   input  wire logic                                         srst,
   input  wire dpo_pkg::dpo_ofs_wr_t                         in_ofs_wr,
   input  wire dpo_pkg::dpo_ofs_wr_t                         ch_ofs_wr,
   input  wire logic [NUM_CH-1:0][dpo_pkg::CH_W-1:0]         active_ref,
   input  wire logic [NUM_CH-1:0][dpo_pkg::PE_W-1:0]         meas_phase_err,
   input  wire logic [NUM_CH-1:0][dpo_pkg::FCW_W-1:0]        lf_freq,
   input  wire logic [dpo_pkg::FCW_W-1:0]                    sys_lf_freq,
   input  wire dpo_pkg::dpo_link_cfg_t [NUM_CH-1:0]          link_cfg,
   input  wire dpo_pkg::dpo_tdc_t [NUM_CH-1:0]               sat_tdc,
   input  wire logic [NUM_CH-1:0]                            sync_en,
   input  wire logic [NUM_CH-1:0][dpo_pkg::PPS_W-1:0]        pps_shift_ns,
   output logic [NUM_CH-1:0][dpo_pkg::PE_W-1:0]              lf_phase_err,
   output logic [NUM_CH-1:0][dpo_pkg::PE_W-1:0]              applied_ofs,
   output logic [NUM_CH-1:0]                                 ref_switched,
   output logic [NUM_CH-1:0][dpo_pkg::FCW_W-1:0]             fod_steer,
   output logic [NUM_CH-1:0]                                 sat_aligned,
   output logic [NUM_CH-1:0]                                 sat_slow,
   output logic [NUM_CH-1:0]                                 fod_sync_req,
   output logic [NUM_CH-1:0][dpo_pkg::PPS_W-1:0]             pps_phase_ofs
);
   import dpo_pkg::*;

   // -----------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------
   if (NUM_CH != (1 << CH_W) || NUM_IN != (1 << CH_W))
   begin : g_bad_size
      $error("channel and input counts must match the index width");
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [PE_W-1:0] sext_ofs(input logic [OFS_W:0] v);
      sext_ofs = {{(PE_W-OFS_W-1){v[OFS_W]}}, v};
   endfunction

   function automatic logic [FCW_W+1:0] sext_fcw(input logic [FCW_W-1:0] v);
      sext_fcw = {{2{v[FCW_W-1]}}, v};
   endfunction

   // clamp a wide sum back into the steering word instead of wrapping,
   // a wrap would flip the frequency sign and glitch the output
   function automatic logic [FCW_W-1:0] sat_fcw(input logic [FCW_W+1:0] v);
      logic [FCW_W-1:0] r;
      r = v[FCW_W-1:0];
      if (v[FCW_W+1:FCW_W-1] != {3{v[FCW_W+1]}})
      begin
         r = {v[FCW_W+1], {(FCW_W-1){~v[FCW_W+1]}}};
      end
      sat_fcw = r;
   endfunction

   function automatic logic [TDC_W-1:0] abs_tdc(input logic [TDC_W-1:0] v);
      abs_tdc = v[TDC_W-1] ? TDC_W'(-v) : v;
   endfunction

   // -----------------------------------------------------------------
   // offset storage
   // -----------------------------------------------------------------
   logic [OFS_W-1:0] in_ofs_q [NUM_IN];
   logic [OFS_W-1:0] ch_ofs_q [NUM_CH];

   // one entry per input, shared by every channel that locks to it
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < NUM_IN; i++)
         begin
            in_ofs_q[i] <= OFS_RST;
         end
      end
      else if (in_ofs_wr.we)
      begin
         in_ofs_q[in_ofs_wr.idx] <= in_ofs_wr.val; // R1 R6
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            ch_ofs_q[c] <= OFS_RST;
         end
      end
      else if (ch_ofs_wr.we)
      begin
         ch_ofs_q[ch_ofs_wr.idx] <= ch_ofs_wr.val; // R2
      end
   end

   // -----------------------------------------------------------------
   // applied offset and loop filter input
   // -----------------------------------------------------------------
   logic [NUM_CH-1:0][CH_W-1:0] ref_q;
   logic [NUM_CH-1:0][PE_W-1:0] ofs_sum;

   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         // signed sum one bit wider, no overflow possible
         ofs_sum[c] = sext_ofs(OFS_W'(in_ofs_q[active_ref[c]]) // R3 R18
                      + {in_ofs_q[active_ref[c]][OFS_W-1], OFS_W'(0)}
                      + {ch_ofs_q[c][OFS_W-1], ch_ofs_q[c]});
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ref_q        <= active_ref; // no false switch pulse after reset
         ref_switched <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            ref_q[c]        <= active_ref[c];
            ref_switched[c] <= (ref_q[c] != active_ref[c]); // R4
         end
      end
   end

   // sum is rebuilt every cycle from the live reference index, so a
   // switchover needs no extra sequencing
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         applied_ofs  <= '0;
         lf_phase_err <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            applied_ofs[c]  <= ofs_sum[c]; // R4
            lf_phase_err[c] <= meas_phase_err[c] + ofs_sum[c]; // R5
         end
      end
   end

   // -----------------------------------------------------------------
   // combo steering
   // -----------------------------------------------------------------
   logic [NUM_CH-1:0][FCW_W-1:0] cmb_steer;

   function automatic logic [FCW_W-1:0] pick_src(input logic [SRC_W-1:0] s,
                                                  input logic             en,
                                                  input int               self);
      logic [FCW_W-1:0] r;
      r = '0;
      if (en && s == SRC_SYS)
      begin
         r = sys_lf_freq; // R8
      end
      else if (en && s < SRC_SYS && int'(s) != self)
      begin
         r = lf_freq[s[CH_W-1:0]]; // R9
      end
      pick_src = r;
   endfunction

   // own loop plus two sources: three channels per group at most
   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         cmb_steer[c] = sat_fcw(sext_fcw(lf_freq[c]) // R7 R8 R9
                        + sext_fcw(pick_src(link_cfg[c].cmb_a_src, link_cfg[c].cmb_a_en, c))
                        + sext_fcw(pick_src(link_cfg[c].cmb_b_src, link_cfg[c].cmb_b_en, c)));
      end
   end

   // -----------------------------------------------------------------
   // satellite alignment
   // -----------------------------------------------------------------
   logic [NUM_CH-1:0][FCW_W-1:0] corr_q;
   logic [NUM_CH-1:0]            sat_ok;

   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         // a satellite chained off another satellite is not served
         sat_ok[c] = link_cfg[c].sat_en // R10
                     && int'(link_cfg[c].sat_src) != c
                     && !link_cfg[link_cfg[c].sat_src].sat_en;
      end
   end

   // small gain keeps the pull gentle; large initial errors converge slowly
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         corr_q <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (!sat_ok[c])
            begin
               corr_q[c] <= '0;
            end
            else if (sat_tdc[c].valid)
            begin
               corr_q[c] <= sat_fcw(sext_fcw(corr_q[c]) // R12 R15
                            + sext_fcw(FCW_W'($signed(sat_tdc[c].phase) >>> ALIGN_SHIFT)));
            end
         end
      end
   end

   // lock stays once reached; sync may then be dropped freely
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sat_aligned <= '0;
         sat_slow    <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (!sat_ok[c])
            begin
               sat_aligned[c] <= 1'b0;
               sat_slow[c]    <= 1'b0;
            end
            else if (sat_tdc[c].valid)
            begin
               if (abs_tdc(sat_tdc[c].phase) <= TDC_W'(ALIGN_TOL))
               begin
                  sat_aligned[c] <= 1'b1; // R16
               end
               sat_slow[c] <= abs_tdc(sat_tdc[c].phase) > TDC_W'(SLOW_DIFF_CNT); // R15
            end
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         fod_sync_req <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            fod_sync_req[c] <= sync_en[c] && !(sat_ok[c] && sat_aligned[c]); // R16
         end
      end
   end

   // -----------------------------------------------------------------
   // steering to the fractional_output_divider
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         fod_steer <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (sat_ok[c])
            begin
               fod_steer[c] <= sat_fcw(sext_fcw(cmb_steer[link_cfg[c].sat_src]) // R11
                               + sext_fcw(corr_q[c])); // R12
            end
            else
            begin
               fod_steer[c] <= cmb_steer[c];
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // pulse-per-second shift
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pps_phase_ofs <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if ($signed(pps_shift_ns[c]) > $signed(PPS_MAX))
            begin
               pps_phase_ofs[c] <= PPS_MAX; // R17
            end
            else if ($signed(pps_shift_ns[c]) < $signed(PPS_MIN))
            begin
               pps_phase_ofs[c] <= PPS_MIN; // R17
            end
            else
            begin
               pps_phase_ofs[c] <= pps_shift_ns[c];
            end
         end
      end
   end

endmodule

// ---- logic/dpo_pkg.sv ----
/*
   shared constants and carrier types for the phase offset and channel
   linking block. assumes one 100 MHz clock and a same-clock servo front end.
*/
// Functional notes
// R1: each clock input keeps its own programmable phase offset.
// R2: each loop channel keeps an extra offset, independent of reference.
// R3: applied offset equals active input offset plus channel offset.
// R4: a reference switchover recomputes the applied offset automatically.
// R5: applied offset adds to measured phase error feeding the loop filter.
// R6: an input shared by channels carries one offset for all of them.
// R7: combo groups hold at most three channels cooperating on steering.
// R8: a receiver takes steering from at most two loops, system loop allowed.
// R9: combo steering reaching outputs always comes from loop filter outputs.
// R10: any channel except system loop may be source or satellite.
// R11: a satellite applies its source's steering from the share bus.
// R12: output converter phase steers the satellite continuously into alignment.
// R13: software sets equal, common-factor master divider frequencies.
// R14: below 1 MHz software enables shared sync for both channels.
// R15: alignment copes with half-period error; above 500 ns is slow.
// R16: alignment survives clearing shared sync after initial alignment.
// R17: a timing slave shifts its pulse-per-second by up to half second.
// R18: offsets are signed two's complement of equal scale.
package dpo_pkg;

   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int NUM_CH   = 8;
   localparam int NUM_IN   = 8;
   localparam int CH_W     = 3;
   localparam int SRC_W    = 4;
   localparam int OFS_W    = 16;
   localparam int PE_W     = 32;
   localparam int FCW_W    = 42;
   localparam int TDC_W    = 24;
   localparam int PPS_W    = 30;

   // -----------------------------------------------------------------
   // codes and timing
   // -----------------------------------------------------------------
   localparam logic [SRC_W-1:0] SRC_SYS      = 4'h8;
   localparam int               CLK_MHZ      = 100;
   localparam int               TDC_LSB_PS   = 50;
   localparam int               SLOW_DIFF_NS = 500;
   localparam int               SLOW_DIFF_CNT = SLOW_DIFF_NS * 1000 / TDC_LSB_PS;
   localparam int               ALIGN_TOL    = 2;
   localparam int               ALIGN_SHIFT  = 4;
   localparam int               HALF_SEC_NS  = 500_000_000;
   localparam logic [PPS_W-1:0] PPS_MAX      = 30'h1DCD_6500;
   localparam logic [PPS_W-1:0] PPS_MIN      = 30'h2232_9B00;
   localparam logic [OFS_W-1:0] OFS_RST      = 16'h0000;

   // -----------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic             sat_en;
      logic [CH_W-1:0]  sat_src;
      logic             cmb_a_en;
      logic [SRC_W-1:0] cmb_a_src;
      logic             cmb_b_en;
      logic [SRC_W-1:0] cmb_b_src;
   } dpo_link_cfg_t;

   typedef struct packed {
      logic             we;
      logic [CH_W-1:0]  idx;
      logic [OFS_W-1:0] val;
   } dpo_ofs_wr_t;

   typedef struct packed {
      logic             valid;
      logic [TDC_W-1:0] phase;
   } dpo_tdc_t;

endpackage

// ---- verif/dpo_phase_link_props.sv ----
/*
   assertions on the ports of dpo_phase_link.
   assumes one clock, sync active-high reset, bound from the bench top.
*/
`timescale 1ns/1ps
module dpo_phase_link_props
#(
   parameter int NUM_CH = dpo_pkg::NUM_CH,
   parameter int NUM_IN = dpo_pkg::NUM_IN
)
(
   input wire logic                                   sys_clk,
   input wire logic                                   srst,
   input wire logic [NUM_CH-1:0][dpo_pkg::CH_W-1:0]   active_ref,
   input wire logic [NUM_CH-1:0][dpo_pkg::PE_W-1:0]   meas_phase_err,
   input wire logic [NUM_CH-1:0][dpo_pkg::FCW_W-1:0]  lf_freq,
   input wire dpo_pkg::dpo_link_cfg_t [NUM_CH-1:0]    link_cfg,
   input wire dpo_pkg::dpo_tdc_t [NUM_CH-1:0]         sat_tdc,
   input wire logic [NUM_CH-1:0]                      sync_en,
   input wire logic [NUM_CH-1:0][dpo_pkg::PPS_W-1:0]  pps_shift_ns,
   input wire logic [NUM_CH-1:0][dpo_pkg::PE_W-1:0]   lf_phase_err,
   input wire logic [NUM_CH-1:0][dpo_pkg::PE_W-1:0]   applied_ofs,
   input wire logic [NUM_CH-1:0]                      ref_switched,
   input wire logic [NUM_CH-1:0][dpo_pkg::FCW_W-1:0]  fod_steer,
   input wire logic [NUM_CH-1:0]                      sat_aligned,
   input wire logic [NUM_CH-1:0]                      sat_slow,
   input wire logic [NUM_CH-1:0]                      fod_sync_req,
   input wire logic [NUM_CH-1:0][dpo_pkg::PPS_W-1:0]  pps_phase_ofs
);
   import dpo_pkg::*;
   localparam int HALF = 500_000_000;
   // channel 3 as satellite of a non-satellite source
   wire sat3 = link_cfg[3].sat_en && link_cfg[3].sat_src != 3'h3
               && !link_cfg[link_cfg[3].sat_src].sat_en;
   wire signed [TDC_W-1:0] ph3 = sat_tdc[3].phase;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   // -----------------------------------------
   // properties
   // -----------------------------------------
   property p_phase_sum;
      !$past(srst) |-> lf_phase_err[0] == $past(meas_phase_err[0]) + applied_ofs[0];
   endproperty
   a_phase_sum: assert property (p_phase_sum) else $error("phase sum wrong");
   property p_switch;
      !$past(srst) && active_ref[0] != $past(active_ref[0]) |-> ##[1:2] ref_switched[0];
   endproperty
   a_switch: assert property (p_switch) else $error("no switch pulse");
   property p_steer;
      !$past(srst) && !$past(link_cfg[0].sat_en | link_cfg[0].cmb_a_en | link_cfg[0].cmb_b_en)
         |-> fod_steer[0] == $past(lf_freq[0]);
   endproperty
   a_steer: assert property (p_steer) else $error("plain steer wrong");
   property p_aligned;
      sat3 && sat_tdc[3].valid && ph3 <= ALIGN_TOL && ph3 >= -ALIGN_TOL |=> sat_aligned[3];
   endproperty
   a_aligned: assert property (p_aligned) else $error("not aligned");
   property p_slow;
      sat3 && sat_tdc[3].valid && (ph3 > SLOW_DIFF_CNT || ph3 < -SLOW_DIFF_CNT) |=> sat_slow[3];
   endproperty
   a_slow: assert property (p_slow) else $error("slow flag missing");
   property p_sync;
      fod_sync_req[3] |-> $past(sync_en[3]);
   endproperty
   a_sync: assert property (p_sync) else $error("sync request without enable");
   property p_pps_in;
      $signed(pps_shift_ns[0]) <= HALF && $signed(pps_shift_ns[0]) >= -HALF
         |=> pps_phase_ofs[0] == $past(pps_shift_ns[0]);
   endproperty
   a_pps_in: assert property (p_pps_in) else $error("pps shift wrong");
   property p_pps_hi;
      $signed(pps_shift_ns[0]) > HALF |=> pps_phase_ofs[0] == PPS_MAX;
   endproperty
   a_pps_hi: assert property (p_pps_hi) else $error("pps high clamp wrong");
   property p_pps_lo;
      $signed(pps_shift_ns[0]) < -HALF |=> pps_phase_ofs[0] == PPS_MIN;
   endproperty
   a_pps_lo: assert property (p_pps_lo) else $error("pps low clamp wrong");
   c_switch: cover property (ref_switched[0]);
   c_align: cover property (sat_aligned[3]);
   c_clamp: cover property (pps_phase_ofs[0] == PPS_MAX);
endmodule

// ---- verif/dpo_servo_model.sv ----
/*
   servo model: offset writes, converter samples, shared sync enables.
   assumes sys_clk; drives at the falling edge.
*/
`timescale 1ns/1ps
module dpo_servo_model
(
   input wire logic                  sys_clk,
   output dpo_pkg::dpo_ofs_wr_t      in_ofs_wr,
   output dpo_pkg::dpo_ofs_wr_t      ch_ofs_wr,
   output dpo_pkg::dpo_tdc_t [7:0]   sat_tdc,
   output logic [7:0]                sync_en
);
   import dpo_pkg::*;
   initial
   begin
      in_ofs_wr = '0;
      ch_ofs_wr = '0;
      sat_tdc = '0;
      sync_en = '0;
   end
   // one offset write: an input entry shared by every channel on it, or a channel entry
   task automatic wr_ofs(input logic chan, input logic [CH_W-1:0] idx,
                         input logic [OFS_W-1:0] val);
      @(negedge sys_clk);
      if (chan)
         ch_ofs_wr <= '{1'b1, idx, val};
      else
         in_ofs_wr <= '{1'b1, idx, val};
      @(negedge sys_clk);
      in_ofs_wr.we <= 1'b0;
      ch_ofs_wr.we <= 1'b0;
   endtask
   // samples assume equal master divider rates on the pair
   task automatic pulse_tdc(input int ch, input logic [TDC_W-1:0] ph);
      @(negedge sys_clk);
      sat_tdc[ch] <= '{1'b1, ph};
      @(negedge sys_clk);
      sat_tdc[ch].valid <= 1'b0;
   endtask
   task automatic set_sync(input logic [7:0] mask);
      @(negedge sys_clk);
      sync_en <= mask;
   endtask
endmodule

// ---- verif/tb_dpo_phase_link.sv ----
/*
   bench for dpo_phase_link: offsets, switchover, combo, satellite, pps.
   assumes the servo model and the checker bound below.
*/
`timescale 1ns/1ps
module tb_dpo_phase_link;
   import dpo_pkg::*;
   logic sys_clk;
   logic srst;
   dpo_ofs_wr_t in_ofs_wr;
   dpo_ofs_wr_t ch_ofs_wr;
   dpo_link_cfg_t [7:0] link_cfg;
   dpo_tdc_t [7:0] sat_tdc;
   logic [7:0][CH_W-1:0] active_ref;
   logic [7:0][PE_W-1:0] meas_phase_err, lf_phase_err, applied_ofs;
   logic [7:0][FCW_W-1:0] lf_freq, fod_steer;
   logic [FCW_W-1:0] sys_lf_freq;
   logic [7:0][PPS_W-1:0] pps_shift_ns, pps_phase_ofs;
   logic [7:0] sync_en, ref_switched, sat_aligned, sat_slow, fod_sync_req;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;

   dpo_phase_link #(.NUM_CH(NUM_CH), .NUM_IN(NUM_IN)) dut_u (.sys_clk, .srst, .in_ofs_wr,
      .ch_ofs_wr, .active_ref, .meas_phase_err, .lf_freq, .sys_lf_freq, .link_cfg, .sat_tdc,
      .sync_en, .pps_shift_ns, .lf_phase_err, .applied_ofs, .ref_switched, .fod_steer,
      .sat_aligned, .sat_slow, .fod_sync_req, .pps_phase_ofs);
   dpo_servo_model srv_u (.sys_clk, .in_ofs_wr, .ch_ofs_wr, .sat_tdc, .sync_en);

   // -----------------------------------------
   // clock, timeout, compare
   // -----------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fail_count++;
         test_done();
      end
   end
   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({63'h0, got}, {63'h0, exp});
   endtask
   task automatic test_done;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // -----------------------------------------
   // sequence
   // -----------------------------------------
   initial
   begin
      srst = 1'b1;
      active_ref = '0;
      meas_phase_err = '0;
      lf_freq = '0;
      sys_lf_freq = '0;
      link_cfg = '0;
      pps_shift_ns = '0;
      pps_shift_ns[0] = 30'h0000_007B;
      repeat (4) @(negedge sys_clk);
      chk_val(pps_phase_ofs[0], 64'h0);
      srst = 1'b0;
      active_ref[0] = 3'h2;
      active_ref[1] = 3'h2;
      meas_phase_err[0] = 32'h0000_03E8;
      @(negedge sys_clk);
      chk_val(pps_phase_ofs[0], 30'h0000_007B);
      srv_u.wr_ofs(1'b0, 3'h2, 16'hFF9C);
      srv_u.wr_ofs(1'b0, 3'h5, 16'h012C);
      srv_u.wr_ofs(1'b1, 3'h0, 16'h0032);
      srv_u.wr_ofs(1'b1, 3'h1, 16'hFFEC);
      @(negedge sys_clk);
      chk_val(applied_ofs[0], 32'hFFFF_FFCE);
      chk_val(applied_ofs[1], 32'hFFFF_FF88);
      chk_val(lf_phase_err[0], 32'h0000_03B6);
      active_ref[0] = 3'h5;
      @(negedge sys_clk);
      chk_bit(ref_switched[0], 1'b1);
      chk_val(applied_ofs[0], 32'h0000_015E);
      @(negedge sys_clk);
      chk_bit(ref_switched[0], 1'b0);
      chk_val(lf_phase_err[0], 32'h0000_0546);
      @(negedge sys_clk);
      chk_bit(ref_switched[0], 1'b0);
      lf_freq[0] = 42'h000_0000_0005;
      lf_freq[2] = 42'h000_0000_03E8;
      sys_lf_freq = 42'h000_0000_000A;
      link_cfg[2] = '{1'b0, 3'h0, 1'b1, SRC_SYS, 1'b1, 4'h0};
      @(negedge sys_clk);
      chk_val(fod_steer[2], 42'h000_0000_03F7);
      link_cfg[2].cmb_b_src = 4'h9;
      @(negedge sys_clk);
      chk_val(fod_steer[2], 42'h000_0000_03F2);
      chk_val(fod_steer[0], 42'h000_0000_0005);
      link_cfg[3] = '{1'b1, 3'h2, 1'b0, 4'h0, 1'b0, 4'h0};
      srv_u.set_sync(8'h0C);
      @(negedge sys_clk);
      chk_val(fod_steer[3], 42'h000_0000_03F2);
      chk_bit(fod_sync_req[3], 1'b1);
      srv_u.pulse_tdc(3, 24'h00_0020);
      @(negedge sys_clk);
      chk_val(fod_steer[3], 42'h000_0000_03F4);
      srv_u.pulse_tdc(3, 24'h00_4E20);
      chk_bit(sat_slow[3], 1'b1);
      chk_bit(sat_aligned[3], 1'b0);
      srv_u.pulse_tdc(3, 24'h00_0001);
      chk_bit(sat_aligned[3], 1'b1);
      chk_bit(sat_slow[3], 1'b0);
      @(negedge sys_clk);
      chk_bit(fod_sync_req[3], 1'b0);
      srv_u.set_sync(8'h00);
      @(negedge sys_clk);
      chk_bit(sat_aligned[3], 1'b1);
      chk_val(fod_steer[3], 42'h000_0000_08D6);
      pps_shift_ns[0] = 30'h1F00_0000;
      link_cfg[4] = '{1'b1, 3'h3, 1'b0, 4'h0, 1'b0, 4'h0};
      lf_freq[4] = 42'h000_0000_0007;
      @(negedge sys_clk);
      chk_val(pps_phase_ofs[0], PPS_MAX);
      chk_val(fod_steer[4], 42'h000_0000_0007);
      pps_shift_ns[0] = 30'h2100_0000;
      @(negedge sys_clk);
      chk_val(pps_phase_ofs[0], PPS_MIN);
      test_done();
   end
endmodule

bind dpo_phase_link dpo_phase_link_props #(.NUM_CH(NUM_CH), .NUM_IN(NUM_IN)) props_u (
   .sys_clk, .srst, .active_ref, .meas_phase_err, .lf_freq, .link_cfg, .sat_tdc, .sync_en,
   .pps_shift_ns, .lf_phase_err, .applied_ofs, .ref_switched, .fod_steer, .sat_aligned,
   .sat_slow, .fod_sync_req, .pps_phase_ofs);
